// ==== hw/ftc_map.svh ====
// Purpose: offsets, fields and reset values of the counter/timer block
// Assumes: 8-bit I/O bus
// Notes: definitions only
`ifndef FTC_MAP_SVH
`define FTC_MAP_SVH
`define FTC_NUM_CH 4
`define FTC_ADDR_CH0 8'hE4
`define FTC_ADDR_CH1 8'hE5
`define FTC_ADDR_CH2 8'hE6
`define FTC_ADDR_CH3 8'hE7
// control byte fields
`define FTC_CB_IRQ_EN 7
`define FTC_CB_COUNTER 6
`define FTC_CB_PRE256 5
`define FTC_CB_RISE 4
`define FTC_CB_MODE 3
`define FTC_CB_TC_NEXT 2
`define FTC_CB_SWRST 1
`define FTC_CB_IS_CTRL 0
// prescaler terminal values
`define FTC_PRE_DIV16 8'h0F
`define FTC_PRE_DIV256 8'hFF
// shared vector field
`define FTC_VEC_HI 7
`define FTC_VEC_LO 3
// reset values
`define FTC_CTRL_RST 8'h00
`define FTC_TC_RST 8'h00
`define FTC_VEC_RST 5'h00
`define FTC_CNT_RST 8'h00
`endif

// ==== hw/ftc_pkg.sv ====
// Purpose: types of the counter/timer block
// Assumes: ftc_map.svh gives the sizes
// Notes: no constants of its own
`include "ftc_map.svh"
package ftc_pkg;
  typedef enum logic [1:0] {
    FTC_IDLE,
    FTC_WAIT_TRIG,
    FTC_RUN
  } ftc_chan_st_t;
  typedef struct packed {
    ftc_chan_st_t st;
    logic [7:0] pre;
    logic [7:0] cnt;
    logic zero;
    logic trig_prev;
  } ftc_chan_t;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
  } ftc_sync_t;
  typedef struct packed {
    logic [`FTC_NUM_CH-1:0][7:0] ctrl;
    logic [`FTC_NUM_CH-1:0][7:0] tc;
    logic [`FTC_NUM_CH-1:0] tc_pend;
    logic [`FTC_NUM_CH-1:0] tc_arm;
    logic [4:0] vec;
    logic [`FTC_NUM_CH-1:0] irq;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] ivec;
    logic ivalid;
    logic int_req;
  } ftc_top_t;
endpackage : ftc_pkg

// ==== hw/ftc_chan_if.sv ====
// Purpose: links the top to one channel
// Assumes: one clock
// Notes: strobes are one cycle
`timescale 1ns/1ps
interface ftc_chan_if;
  logic [7:0] ctrl;
  logic [7:0] tc;
  logic tc_wr;
  logic start;
  logic halt;
  logic trig;
  logic [7:0] cnt;
  logic zero;
  modport top (output ctrl, tc, tc_wr, start, halt, trig, input cnt, zero);
  modport chan (input ctrl, tc, tc_wr, start, halt, trig, output cnt, zero);
endinterface : ftc_chan_if

// ==== hw/ftc_trig_sync.sv ====
// Purpose: brings trigger pins into the clock domain
// Assumes: pins change slower than the clock
// Notes: level moves once stages two and three agree
`timescale 1ns/1ps
module ftc_trig_sync (
  input wire logic i_clk_sys, // system clock
  input wire logic i_srst, // sync reset
  input wire logic [2:0] i_pin, // raw pins
  output logic [2:0] o_lvl // filtered level
);
  ftc_pkg::ftc_sync_t q_ff;
  ftc_pkg::ftc_sync_t nxt_q;

  // s1 feeds only s2; agreement filter reads s2 and s3
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = i_pin;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int b = 0; b < 3; b++) begin
      if (q_ff.s2[b] == q_ff.s3[b]) begin
        nxt_q.lvl[b] = q_ff.s3[b];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_lvl = q_ff.lvl;
endmodule : ftc_trig_sync

// ==== hw/ftc_channel.sv ====
// Purpose: prescaler and down counter of one channel
// Assumes: top decodes writes into strobes
// Notes: never stops by itself
`timescale 1ns/1ps
module ftc_channel (
  input wire logic i_clk_sys, // system clock
  input wire logic i_srst, // sync reset
  ftc_chan_if.chan ch // link to top
);
  ftc_pkg::ftc_chan_t q_ff;
  ftc_pkg::ftc_chan_t nxt_q;

  // counting; zero checked only after a decrement
  always_comb begin
    logic edge_hit;
    logic tick;
    logic [7:0] pre_top;
    logic [7:0] dec;
    edge_hit = 1'b0;
    tick = 1'b0;
    pre_top = 8'h00;
    dec = 8'h00;
    nxt_q = q_ff;
    nxt_q.zero = 1'b0;
    nxt_q.trig_prev = ch.trig;
    edge_hit = (ch.trig != q_ff.trig_prev) && (ch.trig == ch.ctrl[`FTC_CB_RISE]);
    pre_top = ch.ctrl[`FTC_CB_PRE256] ? `FTC_PRE_DIV256 : `FTC_PRE_DIV16;
    if (ch.halt) begin
      nxt_q.st = ftc_pkg::FTC_IDLE;
    end else if (ch.tc_wr && ch.start) begin
      nxt_q.cnt = ch.tc;
      nxt_q.pre = pre_top;
      if (!ch.ctrl[`FTC_CB_COUNTER] && ch.ctrl[`FTC_CB_MODE]) begin
        nxt_q.st = ftc_pkg::FTC_WAIT_TRIG;
      end else begin
        nxt_q.st = ftc_pkg::FTC_RUN;
      end
    end else begin
      case (q_ff.st)
        ftc_pkg::FTC_IDLE: begin
          nxt_q.st = ftc_pkg::FTC_IDLE;
        end
        ftc_pkg::FTC_WAIT_TRIG: begin
          if (edge_hit) begin
            nxt_q.st = ftc_pkg::FTC_RUN;
          end
        end
        ftc_pkg::FTC_RUN: begin
          if (ch.ctrl[`FTC_CB_COUNTER] && !ch.ctrl[`FTC_CB_MODE]) begin
            tick = edge_hit;
          end else if (!ch.ctrl[`FTC_CB_COUNTER] || edge_hit) begin
            // prescaler steps on clock or edge
            if (q_ff.pre == 8'h00) begin
              nxt_q.pre = pre_top;
              tick = 1'b1;
            end else begin
              nxt_q.pre = q_ff.pre - 8'h01;
            end
          end
        end
        default: begin
          nxt_q.st = ftc_pkg::FTC_IDLE;
        end
      endcase
    end
    if (tick) begin
      dec = q_ff.cnt - 8'h01;
      if (dec == 8'h00) begin
        nxt_q.cnt = ch.tc;
        nxt_q.zero = 1'b1;
      end else begin
        nxt_q.cnt = dec;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q_ff <= '{st: ftc_pkg::FTC_IDLE, pre: 8'h00, cnt: `FTC_CNT_RST, zero: 1'b0, trig_prev: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign ch.cnt = q_ff.cnt;
  assign ch.zero = q_ff.zero;
endmodule : ftc_channel

// ==== hw/ftc_top.sv ====
// Purpose: four counter/timer channels on an 8-bit I/O bus
// Assumes: one-cycle read and write strobes, same clock
// Notes: daisy chain and pin sharing sit outside
// How it works
// - four channels, 8-bit counter, /16 or /256
// - one I/O address each, E4 to E7
// - read returns the channel down counter
// - even byte to vector, odd to control
// - bits 2,0 set: next byte is constant
// - bit 7 enables interrupt at zero
// - bit 6 picks counter or timer
// - timer: clock drives prescaler, prescaler counter
// - bit 4 picks trigger edge
// - timer: bit 3 waits for trigger edge
// - counter: bit 3 routes edges via prescaler
// - bit 1 stops; bits 1,2 reset channel
// - constant after reset loads counter, starts
// - otherwise constant waits for next reload
// - zero constant gives 256 decrements
// - vector: shared bits, encoded lowest pending channel
// - vector bit 0 always zero
// - zero outputs can cascade into triggers
// - at zero pulse, request, reload, continue
`timescale 1ns/1ps
module ftc_top (
  input wire logic i_clk_sys, // 20 MHz clock
  input wire logic i_srst, // sync reset, high
  input wire logic [7:0] i_io_addr, // I/O address
  input wire logic i_io_wr, // write strobe
  input wire logic i_io_rd, // read strobe
  input wire logic [7:0] i_io_wdata, // write data
  output logic [7:0] o_io_rdata, // read data
  output logic o_io_rvalid, // read data valid
  input wire logic [3:0] i_count_trigger_input, // trigger pins
  input wire logic [3:1] i_cascade_sel, // 1: trigger from lower zero
  output logic [3:0] o_zero_count_output, // zero pulses
  output logic o_int_req, // interrupt pending
  input wire logic i_int_ack, // acknowledge strobe
  output logic [7:0] o_int_vector, // vector on ack
  output logic o_int_vector_valid // vector valid
);
  localparam int NCH = `FTC_NUM_CH;

  ftc_pkg::ftc_top_t q_ff;
  ftc_pkg::ftc_top_t nxt_q;

  ftc_chan_if ch_if[NCH] ();

  logic [2:0] pin_lvl;
  logic pin0_lvl;
  logic [NCH-1:0] zero_w;
  logic [NCH-1:0][7:0] cnt_w;
  logic [NCH-1:0] wr_sel;
  logic [NCH-1:0] rd_sel;
  logic [NCH-1:0] tc_wr_w;
  logic [NCH-1:0] start_w;
  logic [NCH-1:0] halt_w;
  logic [NCH-1:0] swrst_w;
  logic [NCH-1:0] trig_w;
  logic [1:0] unused_lo; // spare filter bits beside pin 0

  // pins 1..3 through the agreement filter
  ftc_trig_sync u_sync_hi (
    .i_clk_sys (i_clk_sys),
    .i_srst (i_srst),
    .i_pin (i_count_trigger_input[3:1]),
    .o_lvl (pin_lvl)
  );

  // pin 0 never cascades, so it has its own filter
  ftc_trig_sync u_sync_lo (
    .i_clk_sys (i_clk_sys),
    .i_srst (i_srst),
    .i_pin ({2'b00, i_count_trigger_input[0]}),
    .o_lvl ({unused_lo, pin0_lvl})
  );

  // one decoded select per channel address
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      wr_sel[k] = i_io_wr && (i_io_addr == 8'(`FTC_ADDR_CH0 + k));
      rd_sel[k] = i_io_rd && (i_io_addr == 8'(`FTC_ADDR_CH0 + k));
    end
  end

  // write strobes towards each channel
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      tc_wr_w[k] = wr_sel[k] && q_ff.tc_pend[k];
      start_w[k] = tc_wr_w[k] && q_ff.tc_arm[k];
      swrst_w[k] = wr_sel[k] && !q_ff.tc_pend[k] && i_io_wdata[`FTC_CB_IS_CTRL]
        && i_io_wdata[`FTC_CB_SWRST];
      halt_w[k] = swrst_w[k];
    end
  end

  // channel 0 is fed by its pin only; the rest may cascade
  assign trig_w[0] = pin0_lvl;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      if (g > 0) begin : g_route
        // zero pulse is on this clock, so no filter is needed
        assign trig_w[g] = i_cascade_sel[g] ? zero_w[g-1] : pin_lvl[g-1];
      end
      assign ch_if[g].ctrl = q_ff.ctrl[g];
      // the write byte goes straight through so a load in this cycle sees the new constant
      assign ch_if[g].tc = tc_wr_w[g] ? i_io_wdata : q_ff.tc[g];
      assign ch_if[g].tc_wr = tc_wr_w[g];
      assign ch_if[g].start = start_w[g];
      assign ch_if[g].halt = halt_w[g];
      assign ch_if[g].trig = trig_w[g];
      assign cnt_w[g] = ch_if[g].cnt;
      assign zero_w[g] = ch_if[g].zero;
      ftc_channel u_ch (
        .i_clk_sys (i_clk_sys),
        .i_srst (i_srst),
        .ch (ch_if[g])
      );
    end
  endgenerate

  // register file, steering, interrupt requests and vector
  always_comb begin
    logic found;
    logic [1:0] win;
    nxt_q = q_ff;
    found = 1'b0;
    win = 2'b00;
    nxt_q.rvalid = 1'b0;
    nxt_q.ivalid = 1'b0;

    // write steering per channel
    for (int k = 0; k < NCH; k++) begin
      if (wr_sel[k]) begin
        if (q_ff.tc_pend[k]) begin
          nxt_q.tc[k] = i_io_wdata;
          nxt_q.tc_pend[k] = 1'b0;
          nxt_q.tc_arm[k] = 1'b0;
        end else if (i_io_wdata[`FTC_CB_IS_CTRL]) begin
          nxt_q.ctrl[k] = i_io_wdata;
          nxt_q.tc_pend[k] = i_io_wdata[`FTC_CB_TC_NEXT];
          // arm a load only after a full reset
          nxt_q.tc_arm[k] = i_io_wdata[`FTC_CB_TC_NEXT] && i_io_wdata[`FTC_CB_SWRST];
        end else begin
          nxt_q.vec = i_io_wdata[`FTC_VEC_HI:`FTC_VEC_LO];
        end
      end
    end

    // acknowledge picks lowest index as the winner
    for (int k = NCH - 1; k >= 0; k--) begin
      if (q_ff.irq[k]) begin
        found = 1'b1;
        win = 2'(k);
      end
    end
    if (i_int_ack && found) begin
      nxt_q.irq[win] = 1'b0;
      nxt_q.ivec = {q_ff.vec, win, 1'b0};
      nxt_q.ivalid = 1'b1;
    end

    // software reset drops a held request
    for (int k = 0; k < NCH; k++) begin
      if (swrst_w[k]) begin
        nxt_q.irq[k] = 1'b0;
      end
    end

    // a new zero beats any clear in the same cycle
    for (int k = 0; k < NCH; k++) begin
      if (zero_w[k] && q_ff.ctrl[k][`FTC_CB_IRQ_EN]) begin
        nxt_q.irq[k] = 1'b1;
      end
    end
    nxt_q.int_req = |nxt_q.irq;

    // read returns the live down counter
    for (int k = 0; k < NCH; k++) begin
      if (rd_sel[k]) begin
        nxt_q.rdata = cnt_w[k];
        nxt_q.rvalid = 1'b1;
      end
    end
  end

  // all top-level state in one register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q_ff.ctrl <= {NCH{`FTC_CTRL_RST}};
      q_ff.tc <= {NCH{`FTC_TC_RST}};
      q_ff.tc_pend <= '0;
      q_ff.tc_arm <= '0;
      q_ff.vec <= `FTC_VEC_RST;
      q_ff.irq <= '0;
      q_ff.rdata <= 8'h00;
      q_ff.rvalid <= 1'b0;
      q_ff.ivec <= 8'h00;
      q_ff.ivalid <= 1'b0;
      q_ff.int_req <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from flops
  assign o_io_rdata = q_ff.rdata;
  assign o_io_rvalid = q_ff.rvalid;
  assign o_int_req = q_ff.int_req;
  assign o_int_vector = q_ff.ivec;
  assign o_int_vector_valid = q_ff.ivalid;
  assign o_zero_count_output = zero_w;
endmodule : ftc_top

// ==== verification/ftc_chk.sv ====
// Purpose: port checks of the counter/timer block
// Assumes: one clock, sync reset high
// Notes: bound into ftc_top
`timescale 1ns/1ps
module ftc_chk (
  input wire logic i_clk_sys, // clock
  input wire logic i_srst, // reset
  input wire logic [7:0] i_io_addr, // address
  input wire logic i_io_wr, // write strobe
  input wire logic i_io_rd, // read strobe
  input wire logic [7:0] o_io_rdata, // read data
  input wire logic o_io_rvalid, // read valid
  input wire logic [3:0] o_zero_count_output, // zero pulses
  input wire logic o_int_req, // request
  input wire logic i_int_ack, // acknowledge
  input wire logic [7:0] o_int_vector, // vector
  input wire logic o_int_vector_valid // vector valid
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // read aimed at one of the four channel addresses
  logic rd_hit;
  assign rd_hit = i_io_rd && (i_io_addr[7:2] == 6'h39);
  sequence s_rd_hit; rd_hit; endsequence
  sequence s_ack; i_int_ack && o_int_req; endsequence
  property p_rd_ans; s_rd_hit |=> o_io_rvalid; endproperty
  property p_rd_miss; !rd_hit |=> !o_io_rvalid; endproperty
  property p_rd_hold; !rd_hit |=> $stable(o_io_rdata); endproperty
  property p_vec_b0; o_int_vector_valid |-> !o_int_vector[0]; endproperty
  property p_ack; s_ack |=> o_int_vector_valid; endproperty
  property p_no_ack; !i_int_ack |=> !o_int_vector_valid; endproperty
  property p_vec_hold; !i_int_ack |=> $stable(o_int_vector); endproperty
  // trigger edges are at least two clocks apart, so a zero can never repeat at once
  property p_zc_pulse; o_zero_count_output[0] |=> !o_zero_count_output[0]; endproperty
  property p_req_hold; o_int_req && !i_int_ack && !i_io_wr |=> o_int_req; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rd_miss: assert property (p_rd_miss) else $error("stray read valid");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_vec_b0: assert property (p_vec_b0) else $error("vector bit 0 set");
  a_ack: assert property (p_ack) else $error("ack not answered");
  a_no_ack: assert property (p_no_ack) else $error("stray vector valid");
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  a_zc_pulse: assert property (p_zc_pulse) else $error("zero output too long");
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
endmodule : ftc_chk
bind ftc_top ftc_chk ftc_chk_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_io_addr(i_io_addr),
  .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
  .o_zero_count_output(o_zero_count_output), .o_int_req(o_int_req), .i_int_ack(i_int_ack),
  .o_int_vector(o_int_vector), .o_int_vector_valid(o_int_vector_valid));

// ==== verification/ftc_trig_src.sv ====
// Purpose: external trigger sources for the four channels
// Assumes: one source per trigger pin
// Notes: square wave of eight clocks, low when off
`timescale 1ns/1ps
module ftc_trig_src (
  input wire logic i_clk_sys, // clock
  input wire logic [3:0] i_run, // source enables
  output logic [3:0] o_pin // trigger pins
);
  logic [1:0] ph = 2'h0;
  logic [3:0] pin_q = 4'h0;
  // toggle every four clocks; a stopped source drops low so no stale level lingers
  always @(posedge i_clk_sys) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3) pin_q <= ~pin_q & i_run;
    else pin_q <= pin_q & i_run;
  end
  assign o_pin = pin_q;
endmodule : ftc_trig_src

// ==== verification/ftc_tb_top.sv ====
// Purpose: self-checking bench of the counter/timer block
// Assumes: 20 MHz clock, trigger sources in ftc_trig_src
// Notes: periods measured between zero pulses, so sync latency cancels
`timescale 1ns/1ps
module ftc_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_srst, i_io_wr, i_io_rd, i_int_ack, o_io_rvalid, o_int_req, o_int_vector_valid;
  logic [7:0] i_io_addr, i_io_wdata, o_io_rdata, o_int_vector, d, t, v;
  logic [3:0] trig, run, o_zero_count_output;
  logic [3:1] sel;
  int fails = 0;
  int checked = 0;
  int n;
  always #25 i_clk_sys = ~i_clk_sys;
  ftc_top ftc_top_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
    .i_count_trigger_input(trig), .i_cascade_sel(sel), .o_zero_count_output(o_zero_count_output),
    .o_int_req(o_int_req), .i_int_ack(i_int_ack), .o_int_vector(o_int_vector),
    .o_int_vector_valid(o_int_vector_valid));
  ftc_trig_src ftc_trig_src_i (.i_clk_sys(i_clk_sys), .i_run(run), .o_pin(trig));
  task complete_run;
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // inputs move 1 ns after the edge so samples never race the design
  task tick;
    @(posedge i_clk_sys);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [7:0] b);
    i_io_addr = a;
    i_io_wdata = b;
    i_io_wr = 1'b1;
    tick;
    i_io_wr = 1'b0;
    tick;
  endtask : wr
  task prog(input int c, input logic [7:0] k, input logic [7:0] x);
    wr(8'hE4 + 8'(c), k);
    wr(8'hE4 + 8'(c), x);
  endtask : prog
  task rd(input logic [7:0] a, input logic ok);
    i_io_addr = a;
    i_io_rd = 1'b1;
    tick;
    i_io_rd = 1'b0;
    chk(o_io_rvalid, ok);
    d = o_io_rdata;
    tick;
  endtask : rd
  // bounded wait for a zero pulse of channel c
  task wz(input int c);
    n = 0;
    while (o_zero_count_output[c] !== 1'b1) begin
      tick;
      n++;
      if (n > 9000) begin
        fails++;
        complete_run;
      end
    end
  endtask : wz
  task gap(input int c, input int e);
    wz(c);
    tick;
    wz(c);
    chk(n + 1, e);
  endtask : gap
  // clocks between zero pulses: prescale times constant, a zero constant meaning 256
  function automatic int span(input int div, input logic [7:0] k);
    span = div * ((k == 8'h00) ? 256 : int'(k));
  endfunction : span
  // vector: shared bits on top, channel in bits 2..1, bit 0 low
  function automatic logic [7:0] vexp(input logic [7:0] s, input int c);
    vexp = {s[7:3], 2'(c), 1'b0};
  endfunction : vexp
  task cnt(input int c, input int len);
    n = 0;
    repeat (len) begin
      tick;
      if (o_zero_count_output[c] === 1'b1) n++;
    end
  endtask : cnt
  task ack(input logic [7:0] e);
    i_int_ack = 1'b1;
    tick;
    i_int_ack = 1'b0;
    chk(o_int_vector_valid, 1'b1);
    chk(o_int_vector, e);
    tick;
  endtask : ack
  // main sequence: decode, timer, counter, cascade, interrupts
  initial begin
    {i_srst, i_io_wr, i_io_rd, i_int_ack} = 4'h8;
    {i_io_addr, i_io_wdata, run, sel} = 23'h0;
    void'($urandom(27187));
    t = 8'(1 + $urandom % 6);
    v = 8'($urandom) & 8'hFE;
    repeat (6) tick;
    i_srst = 1'b0;
    rd(8'hE3, 1'b0);
    wr(8'hE8, 8'h87);
    rd(8'hE4, 1'b1);
    chk(d, 8'h00);
    prog(0, 8'h07, t);
    rd(8'hE4, 1'b1);
    chk(d, t);
    gap(0, span(16, t));
    prog(0, 8'h27, t);
    gap(0, span(256, t));
    prog(0, 8'h07, 8'h00);
    gap(0, span(16, 8'h00));
    prog(0, 8'h07, 8'h01);
    prog(0, 8'h05, 8'h09);
    rd(8'hE4, 1'b1);
    chk(d == 8'h09, 1'b0);
    gap(0, span(16, 8'h09));
    wr(8'hE4, 8'h03);
    cnt(0, 300);
    chk(n, 0);
    run = 4'h2;
    prog(1, 8'h57, t);
    gap(1, span(8, t));
    prog(1, 8'h47, t);
    gap(1, span(8, t));
    prog(1, 8'h5F, 8'h02);
    gap(1, span(8 * 16, 8'h02));
    prog(1, 8'h57, 8'h02);
    sel = 3'h2;
    prog(2, 8'h57, 8'h03);
    gap(2, span(span(8, 8'h02), 8'h03));
    run = 4'h0;
    prog(3, 8'h0F, 8'h02);
    cnt(3, 200);
    chk(n, 0);
    run = 4'h8;
    gap(3, span(16, 8'h02));
    wr(8'hE5, v);
    wr(8'hE5, 8'h03);
    wr(8'hE6, 8'h03);
    wr(8'hE7, 8'h03);
    prog(0, 8'h87, 8'h01);
    prog(2, 8'h87, 8'h01);
    repeat (40) tick;
    chk(o_int_req, 1'b1);
    wr(8'hE4, 8'h01);
    wr(8'hE6, 8'h01);
    ack(vexp(v, 0));
    ack(vexp(v, 2));
    chk(o_int_req, 1'b0);
    cnt(0, 40);
    chk(o_int_req, 1'b0);
    complete_run;
  end
endmodule : ftc_tb_top
